//--- common/periph_bus_select_defines.vh
/*
  Constants for the on-chip peripheral bus select block: register offsets,
  field positions, reset value and target codes.
  Assumes a 24-bit CPU data address and a 32-bit AXI4-Lite register bus.
*/
`ifndef PERIPH_BUS_SELECT_DEFINES_VH
`define PERIPH_BUS_SELECT_DEFINES_VH

// ----------------------------------------------------------------
// Registers
// ----------------------------------------------------------------
`define ENABLE_REG_OFFSET 16'hf024
`define CONTROL_REG_OFFSET 16'hf028
`define ENABLE_RESET 11'h005
`define ENABLE_WIDTH 11

// ----------------------------------------------------------------
// Enable bit positions
// ----------------------------------------------------------------
`define BIT_CAN1 0
`define BIT_CAN2 1
`define BIT_SMALL_RAM 2
`define BIT_LARGE_RAM 3
`define BIT_RTC 4
`define BIT_FLASH 5
`define BIT_PWM 6
`define BIT_ASYNC 7
`define BIT_SYNC 8
`define BIT_I2C 9
`define BIT_MISC 10

// ----------------------------------------------------------------
// Target codes
// ----------------------------------------------------------------
`define TGT_NONE 4'h0
`define TGT_CAN1 4'h1
`define TGT_CAN2 4'h2
`define TGT_SMALL_RAM 4'h3
`define TGT_LARGE_RAM 4'h4
`define TGT_RTC 4'h5
`define TGT_FLASH 4'h6
`define TGT_PWM 4'h7
`define TGT_ASYNC 4'h8
`define TGT_SYNC 4'h9
`define TGT_I2C 4'ha
`define TGT_MISC 4'hb
`define TGT_INT_FLASH 4'hc
`define TGT_RESERVED 4'hd

`endif

//--- dv/cpu_access_model.sv
/* CPU data access source for the select block.
   Assumes the bench asks for one access at a time. */
`timescale 1ns/100ps
`default_nettype none
module cpu_access_model (
  // Clock
  input wire logic clk,
  // Access
  output logic [23:0] accessAddr,
  output logic accessValid
);
  initial accessAddr = 24'h000000;
  initial accessValid = 1'b0;
  // One-cycle access; address scrambled once no longer valid
  task issue(input logic [23:0] a);
    @(posedge clk);
    accessAddr <= a;
    accessValid <= 1'b1;
    @(posedge clk);
    accessValid <= 1'b0;
    accessAddr <= ~a;
  endtask
endmodule // cpu_access_model
`default_nettype wire

//--- dv/onchip_peripheral_bus_select_asserts.sv
/* Checker for route decode and module enable behaviour.
   Assumes it is bound to the block top and sees its ports only. */
`timescale 1ns/100ps
`default_nettype none
`include "periph_bus_select_defines.vh"
module bus_select_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // System state
  input wire logic global_periph_bus_enable,
  input wire logic boot_mem_select,
  input wire logic emulation_mode,
  // CPU access
  input wire logic [23:0] accessAddr,
  input wire logic accessValid,
  // Route and enables
  input wire logic [3:0] accessTarget,
  input wire logic accessExternal,
  input wire logic accessRouted,
  input wire logic [10:0] moduleEnable,
  input wire logic [10:0] pinGpioRelease
);
  // ------------
  // Access windows, routes and enables
  // ------------
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence sShared;
    accessValid && accessAddr[23:11] == 13'h001d;
  endsequence
  sequence sSmallRam;
    accessValid && accessAddr[23:11] == 13'h001c;
  endsequence
  a_shared_off: assert property (
    sShared ##0 (moduleEnable & 11'h7d3) == 11'h000
    |=> accessExternal && accessRouted) else $error("shared not out");
  a_shared_held: assert property (
    sShared ##0 (moduleEnable & 11'h7d3) != 11'h000
    |=> !accessExternal) else $error("shared went out");
  a_small_ram: assert property (
    sSmallRam |=> accessExternal == !$past(moduleEnable[2]))
    else $error("small ram route");
  a_upper_out: assert property (
    accessValid && accessAddr[23:16] >= 8'h09
    && (moduleEnable & 11'h028) == 11'h000 |=> accessExternal)
    else $error("upper segment not out");
  a_seg8_flash: assert property (
    accessValid && boot_mem_select && accessAddr[23:16] == 8'h08
    |=> accessTarget == `TGT_INT_FLASH) else $error("seg8 flash");
  a_pin_release: assert property (
    pinGpioRelease == ~moduleEnable) else $error("pin release");
  a_emu_enables: assert property (
    emulation_mode [*2] |-> moduleEnable == 11'h7ff)
    else $error("emulation enables");
  a_write_lock: assert property (
    (global_periph_bus_enable && !emulation_mode) [*3]
    |-> $stable(moduleEnable)) else $error("locked enables moved");
  a_reset_value: assert property (
    $rose(reset_n) && !emulation_mode |-> moduleEnable == 11'h005)
    else $error("reset enables");
  a_route_delay: assert property (
    1'b1 |=> accessRouted == $past(accessValid)) else $error("routed");
  a_emu_release: assert property (
    emulation_mode |=> pinGpioRelease == 11'h000)
    else $error("emulation pins released");
endmodule // bus_select_checker
bind onchip_peripheral_bus_select bus_select_checker checker_i (.*);
`default_nettype wire

//--- dv/onchip_peripheral_bus_select_test.sv
/* Self-checking bench for the peripheral bus select block.
   Assumes a 25 MHz clock and the CPU access model beside it. */
`timescale 1ns/100ps
`default_nettype none
`include "periph_bus_select_defines.vh"
module onchip_peripheral_bus_select_test;
  logic clk = '0, reset_n = '0;
  logic [15:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, d;
  logic [3:0] s_axi_wstrb = 4'h3;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0, emulation_mode = '0;
  logic global_periph_bus_enable = '0, boot_mem_select = '0;
  logic [1:0] r;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, accessValid, accessExternal, accessRouted;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [23:0] accessAddr;
  wire [3:0] accessTarget;
  wire [10:0] moduleEnable, pinGpioRelease;
  int failures = 0, compares = 0;
  typedef struct {logic [10:0] e; logic b; logic [23:0] a;
    logic [3:0] t; logic x;} row_t;
  row_t rows[19] = '{'{11'h005, 0, 24'h00e010, `TGT_SMALL_RAM, 0},
    '{11'h000, 0, 24'h00e010, `TGT_NONE, 1},
    '{11'h000, 0, 24'h00e810, `TGT_NONE, 1},
    '{11'h001, 0, 24'h00ee10, `TGT_CAN1, 0},
    '{11'h002, 0, 24'h00ee10, `TGT_CAN2, 0},
    '{11'h010, 0, 24'h00ed10, `TGT_RTC, 0},
    '{11'h040, 0, 24'h00ec10, `TGT_PWM, 0},
    '{11'h080, 0, 24'h00e910, `TGT_ASYNC, 0},
    '{11'h100, 0, 24'h00e810, `TGT_SYNC, 0},
    '{11'h200, 0, 24'h00ea10, `TGT_I2C, 0},
    '{11'h400, 0, 24'h00eb10, `TGT_MISC, 0},
    '{11'h200, 0, 24'h00e910, `TGT_NONE, 0},
    '{11'h008, 0, 24'h0f0010, `TGT_LARGE_RAM, 0},
    '{11'h008, 0, 24'h0a0000, `TGT_NONE, 0},
    '{11'h020, 0, 24'h0a0000, `TGT_FLASH, 0},
    '{11'h020, 0, 24'h0f0000, `TGT_NONE, 0},
    '{11'h000, 0, 24'h0e0000, `TGT_NONE, 1},
    '{11'h000, 1, 24'h080000, `TGT_INT_FLASH, 0},
    '{11'h000, 0, 24'h080000, `TGT_NONE, 1}};
  always #20 clk = ~clk;
  onchip_peripheral_bus_select uut (.*);
  cpu_access_model cpu (.clk(clk), .accessAddr(accessAddr),
    .accessValid(accessValid));
  // ------------
  // Checks and bus cycles
  // ------------
  task chk(input string n, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task wr(input logic [15:0] a, input logic [31:0] v);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task rd(input logic [15:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge clk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task acc(input logic [23:0] a, input logic [3:0] t, input logic x);
    cpu.issue(a);
    @(negedge clk);
    chk("target", t, accessTarget);
    chk("external", x, accessExternal);
    chk("routed", 1'b1, accessRouted);
  endtask
  task wrap_up;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    wrap_up();
  end
  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    chk("enables", 11'h005, moduleEnable);
    chk("release", 11'h7fa, pinGpioRelease);
    rd(`ENABLE_REG_OFFSET);
    chk("reg", 32'h005, d);
    rd(16'h0100);
    chk("rresp", 2'h2, r);
    wr(16'h0100, 32'h1);
    chk("bresp", 2'h2, r);
    $display("test reset done");
    foreach (rows[i]) begin
      wr(`ENABLE_REG_OFFSET, {21'h0, rows[i].e});
      boot_mem_select <= rows[i].b;
      acc(rows[i].a, rows[i].t, rows[i].x);
      chk("release", 11'h7ff ^ rows[i].e, pinGpioRelease);
    end
    $display("test rows done");
    wr(`ENABLE_REG_OFFSET, 32'h0);
    global_periph_bus_enable <= 1'b1;
    acc(24'h080000, `TGT_NONE, 1'b1);
    wr(`ENABLE_REG_OFFSET, 32'h8);
    chk("lockresp", 2'h0, r);
    rd(`ENABLE_REG_OFFSET);
    chk("locked", 32'h0, d);
    global_periph_bus_enable <= 1'b0;
    wr(`ENABLE_REG_OFFSET, 32'h8);
    global_periph_bus_enable <= 1'b1;
    acc(24'h080000, `TGT_RESERVED, 1'b0);
    $display("test lock done");
    emulation_mode <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("emulated", 11'h7ff, moduleEnable);
    chk("emu release", 11'h000, pinGpioRelease);
    rd(`CONTROL_REG_OFFSET);
    chk("status", 32'h0000000a, d);
    $display("test emulation done");
    emulation_mode <= 1'b0;
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    chk("reenables", 11'h005, moduleEnable);
    chk("rerouted", 1'b0, accessRouted);
    rd(`ENABLE_REG_OFFSET);
    chk("rereg", 32'h005, d);
    $display("test second reset done");
    wrap_up();
  end
endmodule // onchip_peripheral_bus_select_test
`default_nettype wire

//--- rtl/onchip_peripheral_bus_select.v
/*
  Peripheral bus select: module enable register behind AXI4-Lite and the
  registered route of each CPU data access.
  Assumes CPU address is valid on accessValid and a clean synchronous reset.
*/
`timescale 1ns/100ps
`default_nettype none
`include "periph_bus_select_defines.vh"

module onchip_peripheral_bus_select #(
  parameter ADDR_WIDTH = 16
) (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // AXI4-Lite slave
  input wire [ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_WIDTH-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // System state
  input wire global_periph_bus_enable,
  input wire boot_mem_select,
  input wire emulation_mode,
  // CPU access
  input wire [23:0] accessAddr,
  input wire accessValid,
  // Route
  output reg [3:0] accessTarget,
  output reg accessExternal,
  output reg accessRouted,
  // Pin release and module enables
  output reg [10:0] moduleEnable,
  output reg [10:0] pinGpioRelease
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  reg [10:0] enableReg;
  reg [15:0] awAddr;
  reg awHeld;
  reg [31:0] wData;
  reg [3:0] wStrb;
  reg wHeld;
  wire [10:0] effEnable;
  wire [3:0] decTarget;
  wire decExternal;
  wire doWrite;
  wire awIsEnable;
  wire [15:0] next_enableLow;

  assign effEnable = emulation_mode ? {11{1'b1}} : enableReg;
  assign doWrite = awHeld & wHeld & ~s_axi_bvalid;
  assign awIsEnable = (awAddr == `ENABLE_REG_OFFSET);
  assign next_enableLow = {
    wStrb[1] ? wData[15:8] : {5'h00, enableReg[10:8]},
    wStrb[0] ? wData[7:0] : enableReg[7:0]};

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!reset_n) begin
      enableReg <= `ENABLE_RESET;
      awAddr <= 16'h0000;
      awHeld <= 1'b0;
      wData <= 32'h00000000;
      wStrb <= 4'h0;
      wHeld <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      if (s_axi_awvalid && !awHeld && !s_axi_awready) begin
        s_axi_awready <= 1'b1;
        awAddr <= s_axi_awaddr[15:0];
        awHeld <= 1'b1;
      end
      if (s_axi_wvalid && !wHeld && !s_axi_wready) begin
        s_axi_wready <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
        wHeld <= 1'b1;
      end
      if (doWrite) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awIsEnable) begin
          s_axi_bresp <= 2'b00;
          if (!global_periph_bus_enable) begin
            enableReg <= next_enableLow[10:0];
          end
        end else if (awAddr == `CONTROL_REG_OFFSET) begin
          s_axi_bresp <= 2'b00;
        end else begin
          s_axi_bresp <= 2'b10;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'b00;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid) begin
        if (s_axi_rready) begin
          s_axi_rvalid <= 1'b0;
        end
      end else if (s_axi_arvalid && !s_axi_arready) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b1;
        if (s_axi_araddr[15:0] == `ENABLE_REG_OFFSET) begin
          s_axi_rdata <= {21'h000000, enableReg};
          s_axi_rresp <= 2'b00;
        end else if (s_axi_araddr[15:0] == `CONTROL_REG_OFFSET) begin
          s_axi_rdata <= {26'h0000000, accessRouted, accessExternal,
            emulation_mode, boot_mem_select, global_periph_bus_enable,
            1'b0};
          s_axi_rresp <= 2'b00;
        end else begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= 2'b10;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Access routing
  // ----------------------------------------------------------------
  periph_target_decode u_decode (
    .addr(accessAddr),
    .enables(effEnable),
    .globalEnable(global_periph_bus_enable),
    .bootMemSelect(boot_mem_select),
    .target(decTarget),
    .toExternal(decExternal)
  );

  always @(posedge clk) begin
    if (!reset_n) begin
      accessTarget <= `TGT_NONE;
      accessExternal <= 1'b0;
      accessRouted <= 1'b0;
      moduleEnable <= `ENABLE_RESET;
      pinGpioRelease <= ~`ENABLE_RESET;
    end else begin
      accessRouted <= accessValid;
      if (accessValid) begin
        accessTarget <= decTarget;
        accessExternal <= decExternal;
      end
      moduleEnable <= effEnable;
      pinGpioRelease <= ~effEnable;
    end
  end

endmodule // onchip_peripheral_bus_select

`default_nettype wire

//--- rtl/periph_target_decode.v
/*
  Combinational decoder: maps a 24-bit data address to the target that
  serves it and says whether the access goes to external memory.
  Assumes enables already forced high in emulation mode by the caller.
*/
`timescale 1ns/100ps
`default_nettype none
`include "periph_bus_select_defines.vh"

module periph_target_decode (
  // Access
  input wire [23:0] addr,
  // Configuration
  input wire [10:0] enables,
  input wire globalEnable,
  input wire bootMemSelect,
  // Result
  output reg [3:0] target,
  output reg toExternal
);

  wire [7:0] seg;
  wire [15:0] off;
  wire sharedAny;
  assign seg = addr[23:16];
  assign off = addr[15:0];
  assign sharedAny = enables[`BIT_CAN1] | enables[`BIT_CAN2] |
    enables[`BIT_RTC] | enables[`BIT_PWM] | enables[`BIT_ASYNC] |
    enables[`BIT_SYNC] | enables[`BIT_I2C] | enables[`BIT_MISC];

  always @* begin
    target = `TGT_NONE;
    toExternal = 1'b1;
    if (seg == 8'h00 && off >= 16'he000 && off <= 16'he7ff) begin
      if (enables[`BIT_SMALL_RAM]) begin
        target = `TGT_SMALL_RAM;
        toExternal = 1'b0;
      end
    end else if (seg == 8'h00 && off >= 16'he800 && off <= 16'hefff) begin
      toExternal = ~sharedAny;
      if (off[15:8] == 8'he8 && enables[`BIT_SYNC]) begin
        target = `TGT_SYNC;
      end else if (off[15:8] == 8'he9 && enables[`BIT_ASYNC]) begin
        target = `TGT_ASYNC;
      end else if (off[15:8] == 8'hea && enables[`BIT_I2C]) begin
        target = `TGT_I2C;
      end else if (off[15:8] == 8'heb && enables[`BIT_MISC]) begin
        target = `TGT_MISC;
      end else if (off[15:8] == 8'hec && enables[`BIT_PWM]) begin
        target = `TGT_PWM;
      end else if (off[15:8] == 8'hed && enables[`BIT_RTC]) begin
        target = `TGT_RTC;
      end else if (off[15:8] >= 8'hec && enables[`BIT_CAN1]) begin
        target = `TGT_CAN1;
      end else if (off[15:8] >= 8'hec && enables[`BIT_CAN2]) begin
        target = `TGT_CAN2;
      end
    end else if (seg == 8'h08) begin
      if (bootMemSelect) begin
        target = `TGT_INT_FLASH;
        toExternal = 1'b0;
      end else if (globalEnable &&
          (enables[`BIT_LARGE_RAM] | enables[`BIT_FLASH])) begin
        target = `TGT_RESERVED;
        toExternal = 1'b0;
      end
    end else if (seg >= 8'h09 && seg <= 8'h0e) begin
      if (enables[`BIT_FLASH]) begin
        target = `TGT_FLASH;
        toExternal = 1'b0;
      end else if (enables[`BIT_LARGE_RAM]) begin
        toExternal = 1'b0;
      end
    end else if (seg == 8'h0f) begin
      if (enables[`BIT_LARGE_RAM]) begin
        target = `TGT_LARGE_RAM;
        toExternal = 1'b0;
      end else if (enables[`BIT_FLASH]) begin
        toExternal = 1'b0;
      end
    end
  end

endmodule // periph_target_decode

`default_nettype wire
